// file: hw/poc_pkg.sv
// package: register offsets, field positions and reset values of the pwm output stage
package poc_pkg;
  // special function register offsets
  localparam logic [7:0] POC_UNIT1_MASK_DATA_ADDR   = 8'hAC;
  localparam logic [7:0] POC_UNIT2_MASK_DATA_ADDR   = 8'hBC;
  localparam logic [7:0] POC_PIN_SEL_B_ADDR         = 8'hC6;
  localparam logic [7:0] POC_UNIT3_MASK_DATA_ADDR   = 8'hCC;
  localparam logic [7:0] POC_OUTPUT_POLARITY_ADDR   = 8'hD6;
  localparam logic [7:0] POC_FAULT_BRAKE_CTRL_ADDR  = 8'hD7;
  localparam logic [7:0] POC_PIN_SEL_A_ADDR         = 8'hDE;
  localparam logic [7:0] POC_UNIT0_MASK_DATA_ADDR   = 8'hFC;
  // reset value shared by all registers
  localparam logic [7:0] POC_REG_RESET              = 8'h00;
  // fault brake control fields
  localparam int         POC_BRAKE_FLAG_BIT         = 7;
  localparam int         POC_BRAKE_EDGE_BIT         = 6;
  // writable masks (reserved bits read zero)
  localparam logic [7:0] POC_SIX_CH_MASK            = 8'h3F;
  localparam logic [7:0] POC_TWO_CH_MASK            = 8'h03;
  localparam logic [7:0] POC_PIN_SEL_B_MASK         = 8'hAE;
  // pin field encodings
  localparam logic [1:0] POC_FIELD_UNIT0            = 2'h0;
  localparam logic [1:0] POC_FIELD_ALT_10           = 2'h2;
  localparam logic [1:0] POC_FIELD_ALT_11           = 2'h3;
  // pin select a bit positions
  localparam int         POC_SEL_P0B3               = 5;
  localparam int         POC_SEL_P0B1               = 4;
  localparam int         POC_SEL_P0B0               = 3;
  localparam int         POC_SEL_P1B0               = 2;
  localparam int         POC_SEL_P1B1               = 1;
  localparam int         POC_SEL_P1B2               = 0;
  // pin select b bit positions
  localparam int         POC_SEL_P1B7               = 7;
  localparam int         POC_SEL_P1B5               = 5;
  localparam int         POC_SEL_P0B4               = 3;
  localparam int         POC_SEL_P0B5               = 2;
  localparam int         POC_SEL_P1B4               = 1;
endpackage : poc_pkg

// file: hw/poc_output_stage.sv
// pwm output conditioning: masking, fault brake, polarity and pin routing
`timescale 1ns/1ps
`default_nettype none
module poc_output_stage
  import poc_pkg::*;
(
  input  wire logic       clock,               // core clock, 125 MHz
  input  wire logic       rst_n,               // asynchronous reset, active low
  input  wire logic       clk_en,              // freezes all state except the reset synchroniser when low
  input  wire logic [7:0] sfr_addr,            // register address
  input  wire logic [7:0] sfr_wdata,           // write data
  input  wire logic       sfr_wr,              // write strobe
  output logic      [7:0] sfr_rdata,           // registered read data
  input  wire logic [5:0] unit0_gen,           // unit 0 generator outputs
  input  wire logic [1:0] unit1_gen,           // unit 1 generator outputs
  input  wire logic [1:0] unit2_gen,           // unit 2 generator outputs
  input  wire logic [1:0] unit3_gen,           // unit 3 generator outputs
  input  wire logic [5:0] unit0_mask_en,       // unit 0 mask enables
  input  wire logic [1:0] unit1_mask_en,       // unit 1 mask enables
  input  wire logic [1:0] unit2_mask_en,       // unit 2 mask enables
  input  wire logic [1:0] unit3_mask_en,       // unit 3 mask enables
  input  wire logic       brake_input_enable,  // fault input detection enable
  input  wire logic       brake_input_pin,     // fault pin, asynchronous
  input  wire logic       unit0_run_bit,       // unit 0 run bit, level
  input  wire logic [1:0] unit1_ch0_pin_field, // unit 1 ch0 pin select
  input  wire logic [1:0] unit1_ch1_pin_field, // unit 1 ch1 pin select
  input  wire logic [1:0] unit2_ch0_pin_field, // unit 2 ch0 pin select
  input  wire logic [1:0] unit2_ch1_pin_field, // unit 2 ch1 pin select
  input  wire logic [1:0] unit3_ch0_pin_field, // unit 3 ch0 pin select
  input  wire logic [1:0] unit3_ch1_pin_field, // unit 3 ch1 pin select
  output logic      [7:0] p0_pwm_value,        // port 0 pwm level per bit
  output logic      [7:0] p0_pwm_sel,          // port 0 bit taken by pwm
  output logic      [7:0] p1_pwm_value,        // port 1 pwm level per bit
  output logic      [7:0] p1_pwm_sel,          // port 1 bit taken by pwm
  output logic            brake_active         // brake override in force
);

  logic [1:0] rst_sync;                 // reset release synchroniser
  logic       rst_n_int;                // synchronised reset
  logic [7:0] unit0_mask_data_reg;      // unit 0 mask data
  logic [7:0] unit1_mask_data_reg;      // unit 1 mask data
  logic [7:0] unit2_mask_data_reg;      // unit 2 mask data
  logic [7:0] unit3_mask_data_reg;      // unit 3 mask data
  logic [7:0] output_polarity_reg;      // unit 0 invert bits
  logic [7:0] fault_brake_control_reg;  // flag, edge select, brake data
  logic [7:0] pin_function_select_a_reg;// pin select a
  logic [7:0] pin_function_select_b_reg;// pin select b
  logic [1:0] brake_sync;               // fault pin synchroniser
  logic       brake_prev_reg;           // previous synced fault level
  logic [2:0] brake_fill_reg;           // samples taken since reset
  logic       brake_hold_reg;           // brake output latched
  logic       brake_edge;               // matching edge seen
  logic [5:0] unit0_cond;               // unit 0 after brake/mask/polarity
  logic [1:0] unit1_cond;               // unit 1 after mask
  logic [1:0] unit2_cond;               // unit 2 after mask
  logic [1:0] unit3_cond;               // unit 3 after mask
  logic [7:0] p0_value_next;            // port 0 value before register
  logic [7:0] p0_sel_next;              // port 0 select before register
  logic [7:0] p1_value_next;            // port 1 value before register
  logic [7:0] p1_sel_next;              // port 1 select before register
  logic [7:0] rdata_next;               // read mux

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync[1];

  // fault pin synchroniser and edge history
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      brake_sync     <= 2'h0;
      brake_prev_reg <= 1'b0;
      brake_fill_reg <= 3'h0;
    end else if (clk_en) begin
      brake_sync     <= {brake_sync[0], brake_input_pin};
      brake_prev_reg <= brake_sync[1];
      brake_fill_reg <= {brake_fill_reg[1:0], 1'b1};
    end
  end

  // edge detection on the second sync stage only; no edge until the
  // history holds real pin samples, so reset cannot fake one
  always_comb begin
    if (!brake_fill_reg[2]) begin
      brake_edge = 1'b0;                               // history still filling
    end else if (fault_brake_control_reg[POC_BRAKE_EDGE_BIT]) begin
      brake_edge = brake_sync[1] & ~brake_prev_reg;
    end else begin
      brake_edge = ~brake_sync[1] & brake_prev_reg;
    end
  end

  // register writes; mask data widths per unit
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      unit0_mask_data_reg       <= POC_REG_RESET;
      unit1_mask_data_reg       <= POC_REG_RESET;
      unit2_mask_data_reg       <= POC_REG_RESET;
      unit3_mask_data_reg       <= POC_REG_RESET;
      output_polarity_reg       <= POC_REG_RESET;
      pin_function_select_a_reg <= POC_REG_RESET;
      pin_function_select_b_reg <= POC_REG_RESET;
    end else if (clk_en && sfr_wr) begin
      unique case (sfr_addr)
        POC_UNIT0_MASK_DATA_ADDR:  unit0_mask_data_reg <= sfr_wdata & POC_SIX_CH_MASK;
        POC_UNIT1_MASK_DATA_ADDR:  unit1_mask_data_reg <= sfr_wdata & POC_TWO_CH_MASK;
        POC_UNIT2_MASK_DATA_ADDR:  unit2_mask_data_reg <= sfr_wdata & POC_TWO_CH_MASK;
        POC_UNIT3_MASK_DATA_ADDR:  unit3_mask_data_reg <= sfr_wdata & POC_TWO_CH_MASK;
        POC_OUTPUT_POLARITY_ADDR:  output_polarity_reg <= sfr_wdata & POC_SIX_CH_MASK;
        POC_PIN_SEL_A_ADDR:        pin_function_select_a_reg <= sfr_wdata & POC_SIX_CH_MASK;
        POC_PIN_SEL_B_ADDR:        pin_function_select_b_reg <= sfr_wdata & POC_PIN_SEL_B_MASK;
        default: ;
      endcase
    end
  end

  // fault brake control: hardware set beats software clear
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      fault_brake_control_reg <= POC_REG_RESET;
    end else if (clk_en) begin
      if (sfr_wr && sfr_addr == POC_FAULT_BRAKE_CTRL_ADDR) begin
        fault_brake_control_reg[6:0] <= sfr_wdata[6:0];
        // flag only clears by software writing 0
        fault_brake_control_reg[POC_BRAKE_FLAG_BIT] <=
          sfr_wdata[POC_BRAKE_FLAG_BIT] | (brake_input_enable & brake_edge);
      end else if (brake_input_enable && brake_edge) begin
        fault_brake_control_reg[POC_BRAKE_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // brake hold: set with flag, released only by run once flag clear
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      brake_hold_reg <= 1'b0;
    end else if (clk_en) begin
      if (brake_input_enable && brake_edge) begin
        brake_hold_reg <= 1'b1;
      end else if (!fault_brake_control_reg[POC_BRAKE_FLAG_BIT] && unit0_run_bit) begin
        brake_hold_reg <= 1'b0;
      end
    end
  end

  // channel conditioning, one slice per unit 0 channel
  genvar ch;
  generate
    for (ch = 0; ch < 6; ch++) begin : g_unit0
      logic pre_pol; // value before polarity
      always_comb begin
        if (brake_hold_reg) begin
          pre_pol = fault_brake_control_reg[ch];
        end else if (unit0_mask_en[ch]) begin
          pre_pol = unit0_mask_data_reg[ch];
        end else begin
          pre_pol = unit0_gen[ch];
        end
      end
      assign unit0_cond[ch] = pre_pol ^ output_polarity_reg[ch];
    end
    for (ch = 0; ch < 2; ch++) begin : g_small
      // two-channel units: mask or pass through
      assign unit1_cond[ch] = unit1_mask_en[ch] ? unit1_mask_data_reg[ch]
                                                : unit1_gen[ch];
      assign unit2_cond[ch] = unit2_mask_en[ch] ? unit2_mask_data_reg[ch]
                                                : unit2_gen[ch];
      assign unit3_cond[ch] = unit3_mask_en[ch] ? unit3_mask_data_reg[ch]
                                                : unit3_gen[ch];
    end
  endgenerate

  // pick unit 0 channel or alternate by field; other codes park low
  function automatic logic pick(input logic [1:0] field, input logic [1:0] alt_code,
                                input logic u0, input logic alt);
    logic r;
    r = 1'b0;
    if (field == POC_FIELD_UNIT0) begin
      r = u0;
    end else if (field == alt_code) begin
      r = alt;
    end
    return r;
  endfunction : pick

  // pin routing
  always_comb begin
    p0_value_next = 8'h00;
    p1_value_next = 8'h00;
    p0_sel_next   = 8'h00;
    p1_sel_next   = 8'h00;
    p0_sel_next[3] = pin_function_select_a_reg[POC_SEL_P0B3];
    p0_sel_next[1] = pin_function_select_a_reg[POC_SEL_P0B1];
    p0_sel_next[0] = pin_function_select_a_reg[POC_SEL_P0B0];
    p1_sel_next[0] = pin_function_select_a_reg[POC_SEL_P1B0];
    p1_sel_next[1] = pin_function_select_a_reg[POC_SEL_P1B1];
    p1_sel_next[2] = pin_function_select_a_reg[POC_SEL_P1B2];
    p1_sel_next[7] = pin_function_select_b_reg[POC_SEL_P1B7];
    p1_sel_next[5] = pin_function_select_b_reg[POC_SEL_P1B5];
    p0_sel_next[4] = pin_function_select_b_reg[POC_SEL_P0B4];
    p0_sel_next[5] = pin_function_select_b_reg[POC_SEL_P0B5];
    p1_sel_next[4] = pin_function_select_b_reg[POC_SEL_P1B4];
    p0_value_next[3] = pick(unit3_ch1_pin_field, POC_FIELD_ALT_11,
                            unit0_cond[5], unit3_cond[1]);
    p0_value_next[1] = pick(unit3_ch0_pin_field, POC_FIELD_ALT_10,
                            unit0_cond[4], unit3_cond[0]);
    p0_value_next[0] = pick(unit2_ch1_pin_field, POC_FIELD_ALT_10,
                            unit0_cond[3], unit2_cond[1]);
    p1_value_next[0] = pick(unit2_ch0_pin_field, POC_FIELD_ALT_10,
                            unit0_cond[2], unit2_cond[0]);
    p1_value_next[1] = pick(unit1_ch1_pin_field, POC_FIELD_ALT_11,
                            unit0_cond[1], unit1_cond[1]);
    p1_value_next[2] = pick(unit1_ch0_pin_field, POC_FIELD_ALT_10,
                            unit0_cond[1], unit1_cond[0]);
    p1_value_next[5] = pick(unit3_ch1_pin_field, POC_FIELD_ALT_11,
                            unit0_cond[5], unit3_cond[1]);
    p0_value_next[4] = pick(unit2_ch1_pin_field, POC_FIELD_ALT_11,
                            unit0_cond[3], unit2_cond[1]);
    p0_value_next[5] = pick(unit2_ch0_pin_field, POC_FIELD_ALT_11,
                            unit0_cond[2], unit2_cond[0]);
    p1_value_next[4] = pick(unit1_ch1_pin_field, POC_FIELD_ALT_10,
                            unit0_cond[1], unit1_cond[1]);
    p1_value_next[7] = unit3_cond[0];
    p0_value_next = p0_value_next & p0_sel_next;
    p1_value_next = p1_value_next & p1_sel_next;
  end

  // read mux; unmapped reads give zero
  always_comb begin
    unique case (sfr_addr)
      POC_UNIT0_MASK_DATA_ADDR:  rdata_next = unit0_mask_data_reg;
      POC_UNIT1_MASK_DATA_ADDR:  rdata_next = unit1_mask_data_reg;
      POC_UNIT2_MASK_DATA_ADDR:  rdata_next = unit2_mask_data_reg;
      POC_UNIT3_MASK_DATA_ADDR:  rdata_next = unit3_mask_data_reg;
      POC_OUTPUT_POLARITY_ADDR:  rdata_next = output_polarity_reg;
      POC_FAULT_BRAKE_CTRL_ADDR: rdata_next = fault_brake_control_reg;
      POC_PIN_SEL_A_ADDR:        rdata_next = pin_function_select_a_reg;
      POC_PIN_SEL_B_ADDR:        rdata_next = pin_function_select_b_reg;
      default:                   rdata_next = 8'h00;
    endcase
  end

  // output registers
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      p0_pwm_value <= 8'h00;
      p0_pwm_sel   <= 8'h00;
      p1_pwm_value <= 8'h00;
      p1_pwm_sel   <= 8'h00;
      brake_active <= 1'b0;
      sfr_rdata    <= 8'h00;
    end else if (clk_en) begin
      p0_pwm_value <= p0_value_next;
      p0_pwm_sel   <= p0_sel_next;
      p1_pwm_value <= p1_value_next;
      p1_pwm_sel   <= p1_sel_next;
      brake_active <= brake_hold_reg;
      sfr_rdata    <= rdata_next;
    end
  end

  // checks
  sequence s_fault_edge;
    clk_en && brake_input_enable && brake_edge;
  endsequence

  AST_FLAG_SET: assert property (@(posedge clock) disable iff (!rst_n_int)
    s_fault_edge |=> fault_brake_control_reg[POC_BRAKE_FLAG_BIT])
    else $error("brake flag not set after fault edge");

  AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (!rst_n_int)
    (fault_brake_control_reg[POC_BRAKE_FLAG_BIT]
      && !(sfr_wr && sfr_addr == POC_FAULT_BRAKE_CTRL_ADDR))
    |=> fault_brake_control_reg[POC_BRAKE_FLAG_BIT])
    else $error("brake flag dropped without software");

  AST_HOLD_UNTIL_RUN: assert property (@(posedge clock) disable iff (!rst_n_int)
    (brake_hold_reg && !unit0_run_bit && !(clk_en && brake_edge)) |=> brake_hold_reg)
    else $error("brake released without run bit");

  AST_BRAKE_OUT: assert property (@(posedge clock) disable iff (!rst_n_int)
    brake_hold_reg |-> unit0_cond == (fault_brake_control_reg[5:0] ^ output_polarity_reg[5:0]))
    else $error("brake data not driven");

  AST_MASK_OUT: assert property (@(posedge clock) disable iff (!rst_n_int)
    (!brake_hold_reg && unit0_mask_en[0])
    |-> unit0_cond[0] == (unit0_mask_data_reg[0] ^ output_polarity_reg[0]))
    else $error("mask data not substituted");

  AST_PASS_OUT: assert property (@(posedge clock) disable iff (!rst_n_int)
    (!unit1_mask_en[0]) |-> unit1_cond[0] == unit1_gen[0])
    else $error("generator not passed");

  AST_GPIO_SEL: assert property (@(posedge clock) disable iff (!rst_n_int)
    clk_en |=> p1_pwm_sel[7] == $past(pin_function_select_b_reg[POC_SEL_P1B7]))
    else $error("pin select not followed");

  AST_ROUTE_P03: assert property (@(posedge clock) disable iff (!rst_n_int)
    (clk_en && pin_function_select_a_reg[POC_SEL_P0B3] && unit3_ch1_pin_field == POC_FIELD_ALT_11)
    |=> p0_pwm_value[3] == $past(unit3_cond[1]))
    else $error("p0.3 alternate routing wrong");

  AST_NARROW_MASK: assert property (@(posedge clock) disable iff (!rst_n_int)
    unit1_mask_data_reg[7:2] == 6'h00)
    else $error("unit 1 mask data too wide");

  // settled fault level changes, once the history is valid
  sequence s_rise_seen;
    clk_en && brake_input_enable && brake_fill_reg[2] && brake_sync[1] && !brake_prev_reg;
  endsequence
  sequence s_fall_seen;
    clk_en && brake_input_enable && brake_fill_reg[2] && !brake_sync[1] && brake_prev_reg;
  endsequence

  AST_EDGE_RISE: assert property (@(posedge clock) disable iff (!rst_n_int)
    s_rise_seen ##0 fault_brake_control_reg[POC_BRAKE_EDGE_BIT] |=> brake_hold_reg)
    else $error("rising fault edge missed");

  AST_EDGE_FALL: assert property (@(posedge clock) disable iff (!rst_n_int)
    s_fall_seen ##0 !fault_brake_control_reg[POC_BRAKE_EDGE_BIT] |=> brake_hold_reg)
    else $error("falling fault edge missed");

  AST_HOLD_RELEASE: assert property (@(posedge clock) disable iff (!rst_n_int)
    (clk_en && brake_hold_reg && unit0_run_bit && !fault_brake_control_reg[POC_BRAKE_FLAG_BIT]
      && !(brake_input_enable && brake_edge)) |=> !brake_hold_reg)
    else $error("brake not released by run bit");

  AST_ROUTE_P14: assert property (@(posedge clock) disable iff (!rst_n_int)
    (clk_en && pin_function_select_b_reg[POC_SEL_P1B4] && unit1_ch1_pin_field == POC_FIELD_ALT_10)
    |=> p1_pwm_value[4] == $past(unit1_cond[1]))
    else $error("p1.4 alternate routing wrong");

endmodule : poc_output_stage
`default_nettype wire

// file: testbench/poc_power_stage.sv
// behavioural power stage model seen from the pwm pins
`timescale 1ns/1ps
`default_nettype none
module poc_power_stage #(
  parameter logic [7:0] IDLE_LEVEL = 8'hFF  // pins left to gpio sit at the pull-up level
) (
  input  wire logic [7:0] p0_pwm_value, // port 0 pwm levels
  input  wire logic [7:0] p0_pwm_sel,   // port 0 pwm ownership
  input  wire logic [7:0] p1_pwm_value, // port 1 pwm levels
  input  wire logic [7:0] p1_pwm_sel,   // port 1 pwm ownership
  output logic      [7:0] p0_pin,       // port 0 level seen by the gate driver
  output logic      [7:0] p1_pin        // port 1 level seen by the gate driver
);
  // an unowned pin never shows a stale pwm level, only the pull-up
  always_comb begin
    p0_pin = (p0_pwm_sel & p0_pwm_value) | (~p0_pwm_sel & IDLE_LEVEL);
    p1_pin = (p1_pwm_sel & p1_pwm_value) | (~p1_pwm_sel & IDLE_LEVEL);
  end
endmodule : poc_power_stage
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the pwm output conditioning stage
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import poc_pkg::*;
  localparam logic [1:0] A10 = POC_FIELD_ALT_10;  // alternate code ten
  localparam logic [1:0] A11 = POC_FIELD_ALT_11;  // alternate code eleven
  logic       clock = 1'b0, rst_n = 1'b0;          // clock and reset
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00; // register bus
  logic       sfr_wr = 1'b0;                       // write strobe
  logic       clk_en = 1'b1;                       // clock enable, low freezes the design
  logic [5:0] gen0 = 6'h00, men0 = 6'h00;          // unit 0 generator and mask enables
  logic [1:0] gen1 = 2'h0, gen2 = 2'h0, gen3 = 2'h0; // units 1 to 3 generators
  logic [1:0] men1 = 2'h0, men2 = 2'h0, men3 = 2'h0; // units 1 to 3 mask enables
  logic [1:0] f10 = 2'h0, f11 = 2'h0, f20 = 2'h0;  // pin fields of units 1 and 2
  logic [1:0] f21 = 2'h0, f30 = 2'h0, f31 = 2'h0;  // pin fields of units 2 and 3
  logic       brake_input_enable = 1'b0, brake_input_pin = 1'b1, unit0_run_bit = 1'b0;
  logic [7:0] sfr_rdata, p0_pwm_value, p0_pwm_sel, p1_pwm_value, p1_pwm_sel, p0_pin, p1_pin;
  logic       brake_active;                        // brake override seen
  logic [7:0] sh [8];                              // shadow of written registers
  logic [7:0] adr [8] = '{POC_UNIT0_MASK_DATA_ADDR, POC_UNIT1_MASK_DATA_ADDR,
    POC_UNIT2_MASK_DATA_ADDR, POC_UNIT3_MASK_DATA_ADDR, POC_OUTPUT_POLARITY_ADDR,
    POC_FAULT_BRAKE_CTRL_ADDR, POC_PIN_SEL_A_ADDR, POC_PIN_SEL_B_ADDR};
  logic [7:0] msk [8] = '{POC_SIX_CH_MASK, POC_TWO_CH_MASK, POC_TWO_CH_MASK, POC_TWO_CH_MASK,
    POC_SIX_CH_MASK, 8'h7F, POC_SIX_CH_MASK, POC_PIN_SEL_B_MASK};
  int         fails = 0, checked = 0;              // mismatch and comparison counts

  poc_output_stage poc_output_stage_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
    .unit0_gen(gen0), .unit1_gen(gen1), .unit2_gen(gen2), .unit3_gen(gen3),
    .unit0_mask_en(men0), .unit1_mask_en(men1), .unit2_mask_en(men2), .unit3_mask_en(men3),
    .brake_input_enable(brake_input_enable), .brake_input_pin(brake_input_pin),
    .unit0_run_bit(unit0_run_bit), .unit1_ch0_pin_field(f10), .unit1_ch1_pin_field(f11),
    .unit2_ch0_pin_field(f20), .unit2_ch1_pin_field(f21), .unit3_ch0_pin_field(f30),
    .unit3_ch1_pin_field(f31), .p0_pwm_value(p0_pwm_value), .p0_pwm_sel(p0_pwm_sel),
    .p1_pwm_value(p1_pwm_value), .p1_pwm_sel(p1_pwm_sel), .brake_active(brake_active));
  poc_power_stage poc_power_stage_i (.p0_pwm_value(p0_pwm_value), .p0_pwm_sel(p0_pwm_sel),
    .p1_pwm_value(p1_pwm_value), .p1_pwm_sel(p1_pwm_sel), .p0_pin(p0_pin), .p1_pin(p1_pin));

  // free-running core clock, 8 ns period
  always #4 clock = ~clock;

  // step past the next rising edge so inputs never move on it
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick

  // one register write, strobe left high for back-to-back writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick();
  endtask : wr

  // registered read, data valid one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_wr = 1'b0;
    sfr_addr = a;
    tick();
    d = sfr_rdata;
  endtask : rd

  // compare one byte and count it
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %02h seen %02h", nm, e, g);
    end
  endtask : chk

  // field decode: unit 0 on code zero, alternate unit on its code, else low
  function automatic logic pick(logic [1:0] f, logic [1:0] alt, logic u0, logic ua);
    return (f == POC_FIELD_UNIT0) ? u0 : ((f == alt) ? ua : 1'b0);
  endfunction : pick

  // expected {p1 value, p1 sel, p0 value, p0 sel} from the shadow state
  function automatic logic [31:0] exp_pins(logic brk);
    logic [5:0] c0;
    logic [1:0] c1, c2, c3;
    logic [7:0] v0, v1, s0, s1;
    c0 = (brk ? sh[5][5:0] : (men0 & sh[0][5:0]) | (~men0 & gen0)) ^ sh[4][5:0];
    c1 = (men1 & sh[1][1:0]) | (~men1 & gen1);
    c2 = (men2 & sh[2][1:0]) | (~men2 & gen2);
    c3 = (men3 & sh[3][1:0]) | (~men3 & gen3);
    s0 = {2'b00, sh[7][2], sh[7][3], sh[6][5], 1'b0, sh[6][4], sh[6][3]};
    s1 = {sh[7][7], 1'b0, sh[7][5], sh[7][1], 1'b0, sh[6][0], sh[6][1], sh[6][2]};
    v0 = {2'b00, pick(f20, A11, c0[2], c2[0]), pick(f21, A11, c0[3], c2[1]),
          pick(f31, A11, c0[5], c3[1]), 1'b0, pick(f30, A10, c0[4], c3[0]),
          pick(f21, A10, c0[3], c2[1])};
    v1 = {c3[0], 1'b0, pick(f31, A11, c0[5], c3[1]), pick(f11, A10, c0[1], c1[1]), 1'b0,
          pick(f10, A10, c0[1], c1[0]), pick(f11, A11, c0[1], c1[1]),
          pick(f20, A10, c0[2], c2[0])};
    return {v1 & s1, s1, v0 & s0, s0};
  endfunction : exp_pins

  // compare all pin outputs and the far-side levels
  task automatic check_pins(input logic brk);
    logic [31:0] e;
    e = exp_pins(brk);
    chk("p0_pwm_sel", e[7:0], p0_pwm_sel);
    chk("p0_pwm_value", e[15:8], p0_pwm_value);
    chk("p1_pwm_sel", e[23:16], p1_pwm_sel);
    chk("p1_pwm_value", e[31:24], p1_pwm_value);
    chk("p0_pin", e[15:8] | ~e[7:0], p0_pin);
    chk("p1_pin", e[31:24] | ~e[23:16], p1_pin);
  endtask : check_pins

  // bounded wait for the brake state, a timeout ends the run
  task automatic wait_ba(input logic lvl);
    int n;
    n = 0;
    while (brake_active !== lvl && n < 20) begin
      tick();
      n++;
    end
    checked++;
    if (brake_active !== lvl) begin
      fails++;
      $display("CHECK FAILED brake_active expected %0b seen %0b", lvl, brake_active);
      final_report();
    end
  endtask : wait_ba

  // counts, verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    logic [7:0] d;
    void'($urandom(32'h280E85C4));
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) tick();
    // reset values, then write masks through back-to-back writes
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], d);
      chk("reset value", POC_REG_RESET, d);
    end
    for (int i = 0; i < 8; i++) begin
      sh[i] = msk[i];
      wr(adr[i], (i == 5) ? 8'h7F : 8'hFF);
    end
    wr(8'hAD, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], d);
      chk("register readback", msk[i], d);
    end
    rd(8'hAD, d);
    chk("unmapped read", 8'h00, d);
    // a write while the clock enable is low must not land
    clk_en = 1'b0;
    wr(POC_UNIT0_MASK_DATA_ADDR, 8'h00);
    clk_en = 1'b1;
    rd(POC_UNIT0_MASK_DATA_ADDR, d);
    chk("frozen write", msk[0], d);
    $display("test registers done");
    // every field code first, then random traffic
    for (int i = 0; i < 40; i++) begin
      for (int r = 0; r < 8; r++) begin
        sh[r] = (i < 4) ? msk[r] : 8'($urandom()) & msk[r];
        wr(adr[r], sh[r]);
      end
      sfr_wr = 1'b0;
      {gen0, gen1, gen2, gen3, men0, men1, men2, men3} = 24'($urandom());
      {f10, f11, f20, f21, f30, f31} = (i < 4) ? {6{2'(i)}} : 12'($urandom());
      repeat (3) tick();
      check_pins(1'b0);
    end
    $display("test routing done");
    // fault brake for each edge polarity
    for (int s = 0; s < 2; s++) begin
      sh[5] = {1'b0, 1'(s), 6'($urandom())};
      wr(POC_FAULT_BRAKE_CTRL_ADDR, sh[5]);
      sfr_wr = 1'b0;
      brake_input_pin = 1'(s);
      repeat (6) tick();
      chk("brake_active disabled", 8'h00, {7'h00, brake_active});
      brake_input_enable = 1'b1;
      tick();
      brake_input_pin = ~1'(s);
      repeat (6) tick();
      chk("brake_active wrong edge", 8'h00, {7'h00, brake_active});
      brake_input_pin = 1'(s);
      wait_ba(1'b1);
      repeat (2) tick();
      check_pins(1'b1);
      rd(POC_FAULT_BRAKE_CTRL_ADDR, d);
      chk("brake flag set", sh[5] | 8'h80, d);
      repeat (20) tick();
      rd(POC_FAULT_BRAKE_CTRL_ADDR, d);
      chk("brake flag kept", sh[5] | 8'h80, d);
      wr(POC_FAULT_BRAKE_CTRL_ADDR, sh[5]);
      sfr_wr = 1'b0;
      repeat (3) tick();
      rd(POC_FAULT_BRAKE_CTRL_ADDR, d);
      chk("brake flag cleared", sh[5], d);
      chk("brake_active held", 8'h01, {7'h00, brake_active});
      check_pins(1'b1);
      unit0_run_bit = 1'b1;
      wait_ba(1'b0);
      repeat (2) tick();
      check_pins(1'b0);
      unit0_run_bit = 1'b0;
      brake_input_enable = 1'b0;
      $display("test brake edge %0d done", s);
    end
    final_report();
  end
endmodule : testbench
`default_nettype wire
